// *** pkg/tmf_pkg.sv ***
`default_nettype none
package tmf_pkg;
  // register byte offsets on the apb window
  localparam logic [11:0] OFF_FLAGS = 12'h000;
  localparam logic [11:0] OFF_ENABLES = 12'h004;
  localparam logic [11:0] OFF_INTCTL = 12'h008;
  localparam logic [11:0] OFF_TCTRL = 12'h00C;
  localparam logic [11:0] OFF_CNT_LO = 12'h010;
  localparam logic [11:0] OFF_CNT_HI = 12'h014;
  localparam logic [11:0] OFF_CCV_LO = 12'h018;
  localparam logic [11:0] OFF_CCV_HI = 12'h01C;
  localparam logic [11:0] OFF_CCCTRL = 12'h020;
  localparam logic [11:0] OFF_STATUS = 12'h024;

  // flag register bit positions
  localparam int FB_OVF = 0;
  localparam int FB_TBM = 1;
  localparam int FB_C1 = 3;
  localparam int FB_C2 = 4;
  localparam int FB_CCP = 5;
  localparam int FB_CONV = 6;
  localparam logic [7:0] FLAG_IMPL_MASK = 8'h7B;
  localparam logic [7:0] FLAG_FULL_ONLY = 8'h62;

  // interrupt control bits
  localparam int IB_GE = 7;
  localparam int IB_PE = 6;

  // timer control bits
  localparam int CB_RUN = 0;
  localparam int CB_EXT = 1;
  localparam int CB_ASYNC = 2;
  localparam int CB_GE = 3;
  localparam int CB_GINV = 4;
  localparam int CB_GSRC = 5;

  // capture/compare control: mode in [1:0]
  localparam int CC_SEV = 2;
  localparam int CC_RISE = 3;
  localparam logic [1:0] MODE_OFF = 2'h0;
  localparam logic [1:0] MODE_CAP = 2'h1;
  localparam logic [1:0] MODE_CMP = 2'h2;
  localparam logic [1:0] MODE_PWM = 2'h3;

  // counter limits and reset values
  localparam logic [15:0] CNT_MAX = 16'hFFFF;
  localparam logic [15:0] CNT_ZERO = 16'h0000;
  localparam logic [15:0] CNT_ONE = 16'h0001;
  localparam logic [31:0] RDATA_IDLE = 32'h0000_0000;

  // pin vector positions
  localparam int PIN_W = 5;
  localparam int PIN_EXT = 0;
  localparam int PIN_GATE = 1;
  localparam int PIN_C1 = 2;
  localparam int PIN_C2 = 3;
  localparam int PIN_CAP = 4;

  typedef struct packed {
    logic psel;
    logic penable;
    logic pwrite;
    logic [11:0] paddr;
    logic [31:0] pwdata;
  } tmf_apb_req_s;

  typedef struct packed {
    logic pready;
    logic pslverr;
    logic [31:0] prdata;
  } tmf_apb_rsp_s;
endpackage : tmf_pkg
`default_nettype wire

// *** core/tmf_pin_sync.sv ***
`timescale 1ns/1ps
`default_nettype none
module tmf_pin_sync
  import tmf_pkg::*;
(
  input wire logic mclk,
  input wire logic rst,
  input wire logic [PIN_W-1:0] pin_raw,
  output logic [PIN_W-1:0] pin_lvl
);
  typedef struct packed {
    logic [PIN_W-1:0] s1;
    logic [PIN_W-1:0] s2;
    logic [PIN_W-1:0] s3;
    logic [PIN_W-1:0] lvl;
  } tmf_sync_st_s;

  tmf_sync_st_s r_q;
  tmf_sync_st_s r_d;

  // three stages; level moves only when stages two and three agree
  always_comb begin
    r_d = r_q;
    r_d.s1 = pin_raw;
    r_d.s2 = r_q.s1;
    r_d.s3 = r_q.s2;
    for (int i = 0; i < PIN_W; i++) begin
      if (r_q.s2[i] == r_q.s3[i]) begin
        r_d.lvl[i] = r_q.s3[i];
      end
    end
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      r_q <= '0;
    end else begin
      r_q <= r_d;
    end
  end

  assign pin_lvl = r_q.lvl;
endmodule : tmf_pin_sync
`default_nettype wire

// *** core/tmf_timer.sv ***
// Implementation choices: register access over APB and the register offsets.
`timescale 1ns/1ps
`default_nettype none
// What this block does
// RULE1 - every flag sets on its event whatever the enable bits hold
// RULE2 - software clears a stale flag before enabling that interrupt
// RULE3 - flag bits 7 and 2 read zero and ignore writes
// RULE4 - bit 0 sets on timer overflow and holds until software writes zero
// RULE5 - bit 1 sets on second timer period match, held until software clears
// RULE6 - bit 4 on comparator two change, bit 3 on comparator one change
// RULE7 - bit 5 sets on capture or compare match, unused in pwm mode
// RULE8 - bit 6 sets when a conversion completes, zero otherwise
// RULE9 - reduced variant reads converter, capture and second timer flags as zero
// RULE10 - 16-bit count climbs to maximum, wraps to zero, sets overflow flag
// RULE11 - overflow request needs timer, peripheral and global enables all set
// RULE12 - the service routine clears the overflow flag itself
// RULE13 - software clears count halves and overflow flag before enabling
// RULE14 - in sleep only the asynchronous external-clock mode keeps counting
// RULE15 - software sets run, timer enable and peripheral enable before sleep
// RULE16 - sleep overflow wakes the core; global enable then vectors it
// RULE17 - gate pin or comparator two gates counting only with gate enable
// RULE18 - gate invert flips polarity for either gate source
// RULE19 - capture mode copies the count into the capture/compare pair
// RULE20 - compare mode raises an event when the pair equals the count
// RULE21 - special event clears the count without setting the overflow flag
// RULE22 - a count write in the same cycle beats the special event clear
// RULE23 - overflow flag sets in the very cycle the count wraps
module tmf_timer
  import tmf_pkg::*;
#(
  parameter bit FULL_VARIANT = 1'b1
) (
  input wire logic mclk,
  input wire logic rst,
  input wire tmf_apb_req_s apb_req,
  output tmf_apb_rsp_s apb_rsp,
  input wire logic [PIN_W-1:0] pins_in,
  input wire logic sleep_in,
  input wire logic conv_done,
  input wire logic timer_b_match,
  output logic irq_req,
  output logic wake_req
);
  typedef struct packed {
    logic [7:0] flags;
    logic [7:0] en;
    logic [7:0] intc;
    logic [7:0] ctrl;
    logic [7:0] ccc;
    logic [15:0] cnt;
    logic [15:0] ccv;
    logic cmp_prev;
    logic ext_prev;
    logic cap_prev;
    logic c1_prev;
    logic c2_prev;
    tmf_apb_rsp_s rsp;
    logic irq;
    logic wake;
  } tmf_timer_st_s;

  tmf_timer_st_s r_q;
  tmf_timer_st_s r_d;
  logic [PIN_W-1:0] pin_lvl;

  // address match, used by every decode below
  function automatic logic is_reg(input logic [11:0] addr, input logic [11:0] off);
    is_reg = (addr == off);
  endfunction : is_reg

  // pins from outside the clock domain
  tmf_pin_sync u_sync (
    .mclk(mclk),
    .rst(rst),
    .pin_raw(pins_in),
    .pin_lvl(pin_lvl)
  );

  // flag positions that exist on this variant
  logic [7:0] fmask;
  assign fmask = FULL_VARIANT ? FLAG_IMPL_MASK : (FLAG_IMPL_MASK & ~FLAG_FULL_ONLY); // RULE3 RULE9

  // apb phases
  logic setup;
  logic acc;
  logic wr;
  logic wr_lo;
  logic wr_hi;
  assign setup = apb_req.psel & ~apb_req.penable & ~r_q.rsp.pready;
  assign acc = apb_req.psel & apb_req.penable & r_q.rsp.pready;
  assign wr = acc & apb_req.pwrite & ~r_q.rsp.pslverr;
  assign wr_lo = wr & is_reg(apb_req.paddr, OFF_CNT_LO);
  assign wr_hi = wr & is_reg(apb_req.paddr, OFF_CNT_HI);

  // count qualification: source, sleep and gate
  logic ext_rise;
  logic tick;
  logic sleep_ok;
  logic gate_in;
  logic gate_ok;
  logic inc;
  logic wrap;
  // external source counts filtered rising edges only
  assign ext_rise = pin_lvl[PIN_EXT] & ~r_q.ext_prev;
  assign tick = r_q.ctrl[CB_EXT] ? ext_rise : 1'b1;
  assign sleep_ok = ~sleep_in | (r_q.ctrl[CB_EXT] & r_q.ctrl[CB_ASYNC]); // RULE14
  assign gate_in = r_q.ctrl[CB_GSRC] ? pin_lvl[PIN_C2] : pin_lvl[PIN_GATE]; // RULE17
  assign gate_ok = ~r_q.ctrl[CB_GE] | (gate_in == r_q.ctrl[CB_GINV]); // RULE17 RULE18
  assign inc = r_q.ctrl[CB_RUN] & tick & sleep_ok & gate_ok;
  assign wrap = inc & (r_q.cnt == CNT_MAX); // RULE10 RULE23

  // capture/compare events
  logic [1:0] mode;
  logic cmp_eq;
  logic cmp_hit;
  logic sev;
  logic cap_hit;
  assign mode = r_q.ccc[1:0];
  assign cmp_eq = FULL_VARIANT & (mode == MODE_CMP) & (r_q.cnt == r_q.ccv); // RULE20
  assign cmp_hit = cmp_eq & ~r_q.cmp_prev;
  assign sev = cmp_hit & r_q.ccc[CC_SEV]; // RULE20
  assign cap_hit = FULL_VARIANT & (mode == MODE_CAP) & (pin_lvl[PIN_CAP] != r_q.cap_prev)
                   & (pin_lvl[PIN_CAP] == r_q.ccc[CC_RISE]); // RULE19

  // event vector in flag positions
  logic [7:0] ev;
  always_comb begin
    ev = 8'h00;
    // a count write or special event pre-empts the step, so no rollover then
    ev[FB_OVF] = wrap & ~wr_lo & ~wr_hi & ~sev; // RULE4 RULE21
    ev[FB_TBM] = timer_b_match; // RULE5
    ev[FB_C1] = pin_lvl[PIN_C1] ^ r_q.c1_prev; // RULE6
    ev[FB_C2] = pin_lvl[PIN_C2] ^ r_q.c2_prev; // RULE6
    ev[FB_CCP] = cap_hit | cmp_hit; // RULE7
    ev[FB_CONV] = conv_done; // RULE8
  end

  // pending requests seen by the core
  logic pend;
  assign pend = |(r_q.flags & r_q.en & fmask);

  // next state of the whole block
  always_comb begin
    r_d = r_q;
    r_d.ext_prev = pin_lvl[PIN_EXT];
    r_d.cap_prev = pin_lvl[PIN_CAP];
    r_d.c1_prev = pin_lvl[PIN_C1];
    r_d.c2_prev = pin_lvl[PIN_C2];
    r_d.cmp_prev = cmp_eq;
    // control registers
    if (wr && is_reg(apb_req.paddr, OFF_ENABLES)) begin
      r_d.en = apb_req.pwdata[7:0] & fmask;
    end else if (wr && is_reg(apb_req.paddr, OFF_INTCTL)) begin
      r_d.intc = apb_req.pwdata[7:0] & 8'hC0;
    end else if (wr && is_reg(apb_req.paddr, OFF_TCTRL)) begin
      r_d.ctrl = apb_req.pwdata[7:0] & 8'h3F;
    end else if (wr && is_reg(apb_req.paddr, OFF_CCCTRL)) begin
      r_d.ccc = apb_req.pwdata[7:0] & 8'h0F;
    end
    // flags: software write, then events set on top so a set beats a clear
    if (wr && is_reg(apb_req.paddr, OFF_FLAGS)) begin
      r_d.flags = (apb_req.pwdata[7:0] | ev) & fmask; // RULE1 RULE3 RULE12
    end else begin
      r_d.flags = (r_q.flags | ev) & fmask; // RULE1 RULE4 RULE5 RULE6
    end
    // counter: write beats special event, special event beats increment
    if (wr_lo || wr_hi) begin
      if (wr_lo) begin
        r_d.cnt[7:0] = apb_req.pwdata[7:0]; // RULE22
      end
      if (wr_hi) begin
        r_d.cnt[15:8] = apb_req.pwdata[7:0]; // RULE22
      end
    end else if (sev) begin
      r_d.cnt = CNT_ZERO; // RULE21
    end else if (inc) begin
      r_d.cnt = r_q.cnt + CNT_ONE; // RULE10
    end
    // capture/compare pair
    if (cap_hit) begin
      r_d.ccv = r_q.cnt; // RULE19
    end else if (wr && is_reg(apb_req.paddr, OFF_CCV_LO)) begin
      r_d.ccv[7:0] = apb_req.pwdata[7:0];
    end else if (wr && is_reg(apb_req.paddr, OFF_CCV_HI)) begin
      r_d.ccv[15:8] = apb_req.pwdata[7:0];
    end
    // apb answer prepared in setup, shown in access
    r_d.rsp.pready = setup;
    r_d.rsp.pslverr = 1'b0;
    r_d.rsp.prdata = RDATA_IDLE;
    if (setup) begin
      if (is_reg(apb_req.paddr, OFF_FLAGS)) begin
        r_d.rsp.prdata[7:0] = r_q.flags & fmask; // RULE3 RULE9
      end else if (is_reg(apb_req.paddr, OFF_ENABLES)) begin
        r_d.rsp.prdata[7:0] = r_q.en;
      end else if (is_reg(apb_req.paddr, OFF_INTCTL)) begin
        r_d.rsp.prdata[7:0] = r_q.intc;
      end else if (is_reg(apb_req.paddr, OFF_TCTRL)) begin
        r_d.rsp.prdata[7:0] = r_q.ctrl;
      end else if (is_reg(apb_req.paddr, OFF_CNT_LO)) begin
        r_d.rsp.prdata[7:0] = r_q.cnt[7:0];
      end else if (is_reg(apb_req.paddr, OFF_CNT_HI)) begin
        r_d.rsp.prdata[7:0] = r_q.cnt[15:8];
      end else if (is_reg(apb_req.paddr, OFF_CCV_LO)) begin
        r_d.rsp.prdata[7:0] = r_q.ccv[7:0];
      end else if (is_reg(apb_req.paddr, OFF_CCV_HI)) begin
        r_d.rsp.prdata[7:0] = r_q.ccv[15:8];
      end else if (is_reg(apb_req.paddr, OFF_CCCTRL)) begin
        r_d.rsp.prdata[7:0] = r_q.ccc;
      end else if (is_reg(apb_req.paddr, OFF_STATUS)) begin
        r_d.rsp.prdata[3:0] = {r_q.wake, r_q.irq, gate_ok, pin_lvl[PIN_C2]};
      end else begin
        r_d.rsp.pslverr = 1'b1;
      end
    end
    // request to the core and wake from sleep
    r_d.irq = pend & r_q.intc[IB_PE] & r_q.intc[IB_GE]; // RULE11 RULE16
    r_d.wake = sleep_in & pend & r_q.intc[IB_PE]; // RULE16
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      r_q <= '0;
    end else begin
      r_q <= r_d;
    end
  end

  // outputs straight from the state flops
  assign apb_rsp = r_q.rsp;
  assign irq_req = r_q.irq;
  assign wake_req = r_q.wake;

  // checks
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (rst);

  AST_UNIMPL_ZERO: assert property ( // RULE3
    (r_q.rsp.pready && is_reg(apb_req.paddr, OFF_FLAGS))
    |-> (r_q.rsp.prdata[7] == 1'b0) && (r_q.rsp.prdata[2] == 1'b0))
    else $error("unimplemented flag bit not zero");

  AST_WRAP_SETS_FLAG: assert property ( // RULE23
    (wrap && !wr_lo && !wr_hi && !sev) |=> (r_q.cnt == CNT_ZERO) && r_q.flags[FB_OVF])
    else $error("wrap did not clear count and set overflow");

  AST_FLAG_STICKY: assert property ( // RULE4
    (r_q.flags[FB_OVF] && !(wr && is_reg(apb_req.paddr, OFF_FLAGS))) |=> r_q.flags[FB_OVF])
    else $error("overflow flag dropped without software");

  AST_SEV_NO_OVF: assert property ( // RULE21
    (sev && !wr_lo && !wr_hi && !r_q.flags[FB_OVF]) |=> (r_q.cnt == CNT_ZERO) && !r_q.flags[FB_OVF])
    else $error("special event did not clear count cleanly");

  AST_WRITE_WINS: assert property ( // RULE22
    (sev && wr_lo) |=> (r_q.cnt[7:0] == $past(apb_req.pwdata[7:0])))
    else $error("special event beat a count write");

  AST_IRQ_GATING: assert property ( // RULE11
    irq_req |-> $past(r_q.intc[IB_GE]) && $past(r_q.intc[IB_PE]) && $past(pend))
    else $error("request without all enables");

  AST_SLEEP_HALT: assert property ( // RULE14
    (sleep_in && !(r_q.ctrl[CB_EXT] && r_q.ctrl[CB_ASYNC]) && !wr_lo && !wr_hi && !sev)
    |=> $stable(r_q.cnt))
    else $error("count moved in sleep outside async mode");

  AST_GATE_HOLD: assert property ( // RULE17
    (r_q.ctrl[CB_GE] && (gate_in != r_q.ctrl[CB_GINV]) && !wr_lo && !wr_hi && !sev)
    |=> $stable(r_q.cnt))
    else $error("count moved while gate closed");

  AST_CAPTURE_COPY: assert property ( // RULE19
    cap_hit |=> (r_q.ccv == $past(r_q.cnt)) && r_q.flags[FB_CCP])
    else $error("capture lost count or flag");

  AST_CONV_FLAG: assert property ( // RULE8
    (conv_done && FULL_VARIANT) |=> r_q.flags[FB_CONV] ##1
    (r_q.flags[FB_CONV] || $past(wr && is_reg(apb_req.paddr, OFF_FLAGS))))
    else $error("conversion flag not set and held");

  AST_WAKE_PATH: assert property ( // RULE16
    (sleep_in && pend && r_q.intc[IB_PE]) |=> wake_req)
    else $error("no wake on pending sleep event");

  AST_CMP_CHANGE: assert property ( // RULE6
    (pin_lvl[PIN_C2] != r_q.c2_prev) |=> r_q.flags[FB_C2])
    else $error("comparator two change not flagged");

  // every event lands in its flag whatever the enables hold
  AST_EVENT_SETS: assert property ( // RULE1
    (|(ev & fmask)) |=> ((r_q.flags & $past(ev & fmask)) == $past(ev & fmask)))
    else $error("event did not set its flag");

  AST_TBM_FLAG: assert property ( // RULE5
    (timer_b_match && FULL_VARIANT) |=> r_q.flags[FB_TBM])
    else $error("second timer match not flagged");

  AST_C1_CHANGE: assert property ( // RULE6
    (pin_lvl[PIN_C1] != r_q.c1_prev) |=> r_q.flags[FB_C1])
    else $error("comparator one change not flagged");

  AST_CCP_FLAG: assert property ( // RULE7
    (cmp_hit || cap_hit) |=> r_q.flags[FB_CCP])
    else $error("capture or compare event not flagged");

  // software side of the overflow flag
  AST_FLAG_WRITE_CLEARS: assert property ( // RULE4
    (wr && is_reg(apb_req.paddr, OFF_FLAGS) && !apb_req.pwdata[FB_OVF] && !wrap) |=> !r_q.flags[FB_OVF])
    else $error("overflow flag ignored a clearing write");

  // positions that do not exist never hold a one
  AST_ABSENT_BITS: assert property ( // RULE9
    ((r_q.flags | r_q.en) & ~fmask) == 8'h00)
    else $error("absent flag position holds a one");

  // counter movement
  AST_COUNT_STEP: assert property ( // RULE10
    (inc && !wr_lo && !wr_hi && !sev) |=> (r_q.cnt == $past(r_q.cnt) + CNT_ONE))
    else $error("count did not step by one");

  AST_GATE_OPEN_COUNTS: assert property ( // RULE18
    (r_q.ctrl[CB_RUN] && r_q.ctrl[CB_GE] && !r_q.ctrl[CB_EXT] && !sleep_in
     && (gate_in == r_q.ctrl[CB_GINV]) && !wr_lo && !wr_hi && !sev)
    |=> (r_q.cnt != $past(r_q.cnt)))
    else $error("count stood while gate open");

  AST_ASYNC_SLEEP_COUNTS: assert property ( // RULE14
    (sleep_in && r_q.ctrl[CB_RUN] && r_q.ctrl[CB_EXT] && r_q.ctrl[CB_ASYNC] && ext_rise && gate_ok
     && !wr_lo && !wr_hi && !sev)
    |=> (r_q.cnt != $past(r_q.cnt)))
    else $error("async count stood in sleep");

  AST_CMP_EVENT: assert property ( // RULE20
    (FULL_VARIANT && (mode == MODE_CMP) && (r_q.cnt == r_q.ccv) && !r_q.cmp_prev)
    |=> r_q.flags[FB_CCP])
    else $error("compare match raised no event");

  // requests to the core
  AST_IRQ_SET: assert property ( // RULE11
    (pend && r_q.intc[IB_PE] && r_q.intc[IB_GE]) |=> irq_req)
    else $error("no request with all enables set");

  AST_WAKE_ONLY_SLEEP: assert property ( // RULE16
    wake_req |-> $past(sleep_in))
    else $error("wake raised outside sleep");
endmodule : tmf_timer
`default_nettype wire

// *** verif/tmf_far_model.sv ***
`timescale 1ns/1ps
`default_nettype none
module tmf_far_model
  import tmf_pkg::*;
(
  input wire logic mclk,
  input wire logic rst,
  input wire logic ext_run,
  input wire logic [PIN_W-1:1] lvl,
  output logic [PIN_W-1:0] pins
);
  logic [1:0] div_q;
  logic ext_q;
  // external count clock, still while not running
  always_ff @(posedge mclk) begin
    if (rst || !ext_run) begin
      div_q <= 2'h0;
      ext_q <= 1'b0;
    end else begin
      div_q <= div_q + 2'h1;
      if (div_q == 2'h3) begin
        ext_q <= ~ext_q;
      end
    end
  end
  // gate, comparator and capture levels pass straight out
  assign pins = {lvl, ext_q};
endmodule : tmf_far_model
`default_nettype wire

// *** verif/tmf_timer_tb.sv ***
`timescale 1ns/1ps
`default_nettype none
module tmf_timer_tb
  import tmf_pkg::*;
;
  logic mclk = 1'b0;
  logic rst = 1'b1;
  tmf_apb_req_s req = '0;
  tmf_apb_rsp_s rsp;
  logic [PIN_W-1:0] pins;
  logic [PIN_W-1:1] lvl = '0;
  logic sleep_in = 1'b0;
  logic conv_done = 1'b0;
  logic tb_match = 1'b0;
  logic ext_run = 1'b0;
  logic irq_req;
  logic wake_req;
  logic [31:0] d;
  logic [31:0] e;
  int n_mismatch = 0;
  int n_compared = 0;
  int k;

  // 200 MHz clock
  always #2.5 mclk = ~mclk;

  tmf_timer #(.FULL_VARIANT(1'b1)) DUT (.mclk(mclk), .rst(rst), .apb_req(req), .apb_rsp(rsp),
    .pins_in(pins), .sleep_in(sleep_in), .conv_done(conv_done), .timer_b_match(tb_match),
    .irq_req(irq_req), .wake_req(wake_req));
  tmf_far_model FAR (.mclk(mclk), .rst(rst), .ext_run(ext_run), .lvl(lvl), .pins(pins));

  // verdict and end of run
  task automatic stop_test;
    $display("compared %0d mismatches %0d", n_compared, n_mismatch);
    if (n_mismatch == 0 && n_compared > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask : stop_test

  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  // one apb transfer, held until pready
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] wd,
                     output logic [31:0] rd, output logic err);
    int i;
    @(posedge mclk);
    req <= '{1'b1, 1'b0, wr, a, wd};
    @(posedge mclk);
    req.penable <= 1'b1;
    for (i = 0; i < 20; i++) begin
      @(posedge mclk);
      if (rsp.pready === 1'b1) break;
    end
    rd = rsp.prdata;
    err = rsp.pslverr;
    req <= '0;
    if (i == 20) begin
      n_mismatch++;
      stop_test();
    end
  endtask : apb

  task automatic wr(input logic [11:0] a, input logic [7:0] v);
    logic [31:0] x;
    logic er;
    apb(1'b1, a, {24'h0, v}, x, er);
  endtask : wr

  task automatic rd(input logic [11:0] a, output logic [31:0] v);
    logic er;
    apb(1'b0, a, 32'h0, v, er);
  endtask : rd

  // read flags until all masked bits are set
  task automatic poll(input logic [7:0] m);
    int i;
    for (i = 0; i < 40; i++) begin
      rd(OFF_FLAGS, d);
      if ((d[7:0] & m) == m) break;
    end
    if (i == 40) begin
      n_mismatch++;
      stop_test();
    end
  endtask : poll

  // main sequence
  initial begin
    repeat (8) @(posedge mclk);
    rst <= 1'b0;
    rd(OFF_FLAGS, d);
    check("flags reset", d, 32'h0);
    apb(1'b0, 12'h0FC, 32'h0, d, e[0]);
    check("unmapped error", {31'h0, e[0]}, 32'h1);
    wr(OFF_FLAGS, 8'hFF);
    rd(OFF_FLAGS, d);
    check("flags all ones", d, {24'h0, FLAG_IMPL_MASK});
    wr(OFF_FLAGS, 8'h00);
    // event pulses with every enable off
    @(posedge mclk);
    conv_done <= 1'b1;
    tb_match <= 1'b1;
    @(posedge mclk);
    conv_done <= 1'b0;
    tb_match <= 1'b0;
    rd(OFF_FLAGS, d);
    check("event flags", d, 32'h42);
    lvl[PIN_C1] <= 1'b1;
    lvl[PIN_C2] <= 1'b1;
    poll(8'h18);
    check("comparator flags", d, 32'h5A);
    wr(OFF_FLAGS, 8'h00);
    // rollover from FFFE
    wr(OFF_CNT_LO, 8'hFE);
    wr(OFF_CNT_HI, 8'hFF);
    wr(OFF_TCTRL, 8'h01);
    repeat (4) @(posedge mclk);
    rd(OFF_FLAGS, d);
    check("overflow flag", d, 32'h01);
    rd(OFF_CNT_HI, d);
    check("count wrapped", d, 32'h0);
    check("irq enables off", {31'h0, irq_req}, 32'h0);
    wr(OFF_ENABLES, 8'h01);
    wr(OFF_INTCTL, 8'h40);
    repeat (2) @(posedge mclk);
    check("irq global off", {31'h0, irq_req}, 32'h0);
    wr(OFF_INTCTL, 8'hC0);
    repeat (2) @(posedge mclk);
    check("irq all on", {31'h0, irq_req}, 32'h1);
    wr(OFF_FLAGS, 8'h00);
    repeat (2) @(posedge mclk);
    check("irq retired", {31'h0, irq_req}, 32'h0);
    // gate closed, then inverted
    lvl[PIN_GATE] <= 1'b1;
    wr(OFF_TCTRL, 8'h09);
    rd(OFF_CNT_LO, d);
    rd(OFF_CNT_LO, e);
    check("gate holds count", e, d);
    wr(OFF_TCTRL, 8'h19);
    rd(OFF_CNT_LO, d);
    rd(OFF_CNT_LO, e);
    check("inverted gate counts", {31'h0, e != d}, 32'h1);
    // comparator two as gate source, high level shuts it
    wr(OFF_TCTRL, 8'h29);
    rd(OFF_CNT_LO, d);
    rd(OFF_CNT_LO, e);
    check("comparator gate holds", e, d);
    rd(OFF_STATUS, d);
    check("status gate shut", d, 32'h1);
    // internal clock halts in sleep
    wr(OFF_TCTRL, 8'h01);
    sleep_in <= 1'b1;
    rd(OFF_CNT_LO, d);
    rd(OFF_CNT_LO, e);
    check("sleep halts count", e, d);
    sleep_in <= 1'b0;
    // asynchronous external count wakes the core
    wr(OFF_TCTRL, 8'h00);
    wr(OFF_INTCTL, 8'h40);
    wr(OFF_CNT_LO, 8'hFE);
    wr(OFF_CNT_HI, 8'hFF);
    ext_run <= 1'b1;
    wr(OFF_TCTRL, 8'h07);
    sleep_in <= 1'b1;
    for (k = 0; k < 200 && wake_req !== 1'b1; k++)
      @(posedge mclk);
    check("sleep wake", {31'h0, wake_req}, 32'h1);
    if (k == 200)
      stop_test();
    check("no irq without global", {31'h0, irq_req}, 32'h0);
    sleep_in <= 1'b0;
    ext_run <= 1'b0;
    wr(OFF_TCTRL, 8'h00);
    wr(OFF_FLAGS, 8'h00);
    // compare with special event as period
    wr(OFF_CNT_LO, 8'h00);
    wr(OFF_CNT_HI, 8'h00);
    wr(OFF_CCV_LO, 8'h20);
    wr(OFF_CCV_HI, 8'h00);
    wr(OFF_CCCTRL, 8'h06);
    wr(OFF_TCTRL, 8'h01);
    poll(8'h20);
    repeat (100) @(posedge mclk);
    rd(OFF_CNT_LO, d);
    check("count within period", {31'h0, d[7:0] <= 8'h20}, 32'h1);
    rd(OFF_FLAGS, d);
    check("match flag only", d, 32'h20);
    // capture of a stopped count
    wr(OFF_TCTRL, 8'h00);
    wr(OFF_FLAGS, 8'h00);
    wr(OFF_CNT_LO, 8'h5A);
    wr(OFF_CNT_HI, 8'h3C);
    wr(OFF_CCCTRL, 8'h09);
    lvl[PIN_CAP] <= 1'b1;
    poll(8'h20);
    check("capture flag", d, 32'h20);
    rd(OFF_CCV_LO, d);
    check("capture low", d, 32'h5A);
    rd(OFF_CCV_HI, d);
    check("capture high", d, 32'h3C);
    stop_test();
  end
endmodule : tmf_timer_tb
`default_nettype wire
